// ===== design/pcd_decoder.sv
/*
  Packet command decoder: samples the receive clock and the row and column pins,
  rebuilds packets, decodes row, column, mask and extended commands and issues
  one-cycle strobes toward bank and power logic; keeps the power state, the
  write buffer tags and the refresh row counter.
  Assumes rclk_in and the pins are asynchronous to clk_in and much slower.
*/
`timescale 1ns/10ps
module pcd_decoder
  import pcd_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    resetn_in,
  input  wire logic                    ce_in,
  input  wire logic                    rclk_in,
  input  wire logic [PCD_ROW_PINS-1:0] row_pins_in,
  input  wire logic [PCD_COL_PINS-1:0] col_pins_in,
  input  wire logic [4:0]              unit_identifier_in,
  output logic                         open_row_cmd_out,
  output logic                         bank_close_cmd_out,
  output logic                         refresh_open_cmd_out,
  output logic                         refresh_close_cmd_out,
  output logic                         deep_sleep_cmd_out,
  output logic                         light_sleep_cmd_out,
  output logic                         light_sleep_if_cmd_out,
  output logic                         row_standby_cmd_out,
  output logic                         attention_cmd_out,
  output logic                         thermal_trim_cmd_out,
  output logic                         thermal_trim_enable_cmd_out,
  output logic [4:0]                   row_bank_addr_out,
  output logic [8:0]                   row_index_out,
  output logic [8:0]                   refresh_row_counter_out,
  output logic                         col_write_out,
  output logic                         col_read_out,
  output logic [4:0]                   col_bank_addr_out,
  output logic [6:0]                   column_index_out,
  output logic                         retire_out,
  output logic [4:0]                   retire_bank_addr_out,
  output logic [6:0]                   retire_column_out,
  output logic [7:0]                   lane_a_byte_enables_out,
  output logic [7:0]                   lane_b_byte_enables_out,
  output logic                         ext_bank_close_cmd_out,
  output logic [4:0]                   ext_bank_addr_out,
  output logic [3:0]                   power_state_out
);
  import pcd_pkg::*;

  logic                    rclk_s1_q;
  logic                    rclk_s2_q;
  logic                    rclk_s3_q;
  logic [PCD_ROW_PINS-1:0] row_s1_q;
  logic [PCD_ROW_PINS-1:0] row_s2_q;
  logic [PCD_COL_PINS-1:0] col_s1_q;
  logic [PCD_COL_PINS-1:0] col_s2_q;
  logic                    link_edge;
  logic [PCD_ROW_BITS-1:0] row_pkt;
  logic                    row_vld;
  logic [PCD_COL_BITS-1:0] col_pkt;
  logic                    col_vld;
  logic                    unit_hit;
  logic                    broadcast;
  pcd_pwr_t                pwr_q;
  pcd_pwr_t                pwr_d;
  logic                    wbuf_vld_q;
  logic [4:0]              wbuf_bank_q;
  logic [6:0]              wbuf_col_q;
  logic [8:0]              refresh_q;
  // decoded events
  logic [10:0]             rop;
  logic                    row_op;
  logic                    low_pwr;
  logic                    is_open;
  logic                    is_close;
  logic                    is_ref_open;
  logic                    is_ref_close;
  logic                    is_deep;
  logic                    is_nap;
  logic                    is_nap_if;
  logic                    is_active_listen_state;
  logic                    is_idle_power_state;
  logic                    is_trim;
  logic                    is_trim_en;
  logic                    col_take;
  logic                    col_hit;
  logic [2:0]              cop_low;
  logic                    is_write;
  logic                    is_read;
  logic                    is_retire;
  logic                    is_col_idle_power_state;
  logic                    ext_hit;
  logic [4:0]              xop;
  logic                    is_ext_close;
  logic                    is_ext_idle_power_state;

  // two-flop synchronisers for the receive clock and all pins
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rclk_s1_q <= 1'b0;
      rclk_s2_q <= 1'b0;
      rclk_s3_q <= 1'b0;
      row_s1_q  <= '0;
      row_s2_q  <= '0;
      col_s1_q  <= '0;
      col_s2_q  <= '0;
    end else if (ce_in) begin
      rclk_s1_q <= rclk_in;
      rclk_s2_q <= rclk_s1_q;
      rclk_s3_q <= rclk_s2_q;
      row_s1_q  <= row_pins_in;
      row_s2_q  <= row_s1_q;
      col_s1_q  <= col_pins_in;
      col_s2_q  <= col_s1_q;
    end
  end

  // both receive-clock edges carry a slot
  assign link_edge = rclk_s2_q ^ rclk_s3_q;

  // row group deserialiser, framed by either high select bit
  pcd_deser #(
    .PINS  (PCD_ROW_PINS),
    .SLOTS (PCD_ROW_SLOTS),
    .FRAME (PCD_ROW_FRAME)
  ) u_row_deser (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .ce_in      (ce_in),
    .edge_in    (link_edge),
    .pins_in    (row_s2_q),
    .packet_out (row_pkt),
    .valid_out  (row_vld)
  );

  // column group deserialiser, framed by the start marker only
  pcd_deser #(
    .PINS  (PCD_COL_PINS),
    .SLOTS (PCD_COL_SLOTS),
    .FRAME (PCD_COL_FRAME)
  ) u_col_deser (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .ce_in      (ce_in),
    .edge_in    (link_edge),
    .pins_in    (col_s2_q),
    .packet_out (col_pkt),
    .valid_out  (col_vld)
  );

  pcd_unit_match u_match (
    .sel_true_in        (row_pkt[PCD_ROW_SEL_T]),
    .sel_false_in       (row_pkt[PCD_ROW_SEL_F]),
    .unit_low_in        (row_pkt[PCD_ROW_UNIT_HI:PCD_ROW_UNIT_LO]),
    .unit_identifier_in (unit_identifier_in),
    .unit_hit_out       (unit_hit),
    .broadcast_out      (broadcast)
  );

  // row packet decode; don't-care fields let commands combine
  always_comb begin
    rop          = row_pkt[PCD_ROW_OP_HI:0];
    row_op       = row_vld && unit_hit && !row_pkt[PCD_ROW_KIND];
    low_pwr      = (rop[2:0] == PCD_ROP_LOW_PWR);
    is_open      = row_vld && unit_hit && row_pkt[PCD_ROW_KIND];
    is_close     = row_op && low_pwr && (rop[10:6] == PCD_ROP_CLOSE);
    is_ref_open  = row_op && low_pwr && (rop[10:4] == PCD_ROP_REF_OPN);
    is_ref_close = row_op && low_pwr && (rop[10:4] == PCD_ROP_REF_CLS);
    is_deep      = row_op && low_pwr && (rop[8:4] == PCD_ROP_DEEP);
    is_nap       = row_op && low_pwr && (rop[8:4] == PCD_ROP_NAP);
    is_nap_if    = row_op && low_pwr && (rop[8:4] == PCD_ROP_NAP_IF);
    is_active_listen_state      = row_op && low_pwr && !rop[3] && (rop != 11'h000);
    is_idle_power_state      = row_op && low_pwr && rop[3];
    is_trim      = row_op && (rop[10:4] == 7'h00) && (rop[2:0] == PCD_ROP_TRIM);
    is_trim_en   = row_op && (rop[10:4] == 7'h00) && (rop[2:0] == PCD_ROP_TRIM_EN);
  end

  // column, mask and extended decode; reserved codes fall through unused
  always_comb begin
    col_take     = col_vld && (pwr_q == PCD_ACTIVE_LISTEN);
    col_hit      = pcd_unit_eq(col_pkt[PCD_COL_UNIT_HI:PCD_COL_UNIT_LO], unit_identifier_in);
    cop_low      = col_pkt[PCD_COL_OP_LO+2:PCD_COL_OP_LO];
    is_write     = col_take && col_hit && (cop_low == PCD_COP_WRITE);
    is_read      = col_take && col_hit && (cop_low == PCD_COP_READ);
    // retire on any other unit, or on retire/write to this unit
    is_retire    = col_take && wbuf_vld_q &&
                   (!col_hit || cop_low == PCD_COP_RETIRE || cop_low == PCD_COP_WRITE);
    is_col_idle_power_state  = col_take && col_hit && col_pkt[PCD_COL_OP_HI];
    ext_hit      = col_take && !col_pkt[PCD_COL_KIND] &&
                   pcd_unit_eq(col_pkt[PCD_EXT_UNIT_HI:PCD_EXT_UNIT_LO], unit_identifier_in);
    xop          = col_pkt[PCD_EXT_OP_HI:PCD_EXT_OP_LO];
    is_ext_close = ext_hit && xop[4] && !xop[0];
    is_ext_idle_power_state  = ext_hit && xop[1] && !xop[0];
  end

  // power state: sleep moves outrank standby, standby outranks attention
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PCD_ACTIVE_LISTEN: begin
        if (is_deep) begin
          pwr_d = PCD_DEEP_POWER;
        end else if (is_nap) begin
          pwr_d = PCD_LIGHT_SLEEP;
        end else if (is_idle_power_state || is_col_idle_power_state || is_ext_idle_power_state) begin
          pwr_d = PCD_IDLE_POWER;
        end
      end
      PCD_IDLE_POWER: begin
        if (is_deep) begin
          pwr_d = PCD_DEEP_POWER;
        end else if (is_nap || is_nap_if) begin
          pwr_d = PCD_LIGHT_SLEEP;
        end else if (is_open || (is_active_listen_state && !broadcast)) begin
          pwr_d = PCD_ACTIVE_LISTEN;
        end
      end
      PCD_LIGHT_SLEEP: begin
        if (is_deep) begin
          pwr_d = PCD_DEEP_POWER;
        end else if (is_open || (is_active_listen_state && !broadcast)) begin
          pwr_d = PCD_ACTIVE_LISTEN;
        end
      end
      PCD_DEEP_POWER: begin
        if (is_open || (is_active_listen_state && !broadcast)) begin
          pwr_d = PCD_ACTIVE_LISTEN;
        end
      end
      default: begin
        pwr_d = PCD_PWR_RST;
      end
    endcase
  end

  // power state register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pwr_q <= PCD_PWR_RST;
    end else if (ce_in) begin
      pwr_q <= pwr_d;
    end
  end

  // write buffer tags; a new write wins over the retire of the old one
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wbuf_vld_q  <= 1'b0;
      wbuf_bank_q <= '0;
      wbuf_col_q  <= '0;
    end else if (ce_in) begin
      if (is_write) begin
        wbuf_vld_q  <= 1'b1;
        wbuf_bank_q <= col_pkt[PCD_COL_BANK_HI:PCD_COL_BANK_LO];
        wbuf_col_q  <= col_pkt[PCD_COL_IDX_HI:PCD_COL_IDX_LO];
      end else if (is_retire) begin
        wbuf_vld_q <= 1'b0;
      end
    end
  end

  // refresh row counter steps after the last bank is refreshed
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      refresh_q <= PCD_REFRESH_RST;
    end else if (ce_in) begin
      if (is_ref_open && row_pkt[PCD_ROW_BANK_HI:PCD_ROW_BANK_LO] == PCD_LAST_BANK) begin
        refresh_q <= refresh_q + 9'h001;
      end
    end
  end

  // row strobes and their address fields
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      open_row_cmd_out            <= 1'b0;
      bank_close_cmd_out          <= 1'b0;
      refresh_open_cmd_out        <= 1'b0;
      refresh_close_cmd_out       <= 1'b0;
      deep_sleep_cmd_out          <= 1'b0;
      light_sleep_cmd_out         <= 1'b0;
      light_sleep_if_cmd_out      <= 1'b0;
      row_standby_cmd_out         <= 1'b0;
      attention_cmd_out           <= 1'b0;
      thermal_trim_cmd_out        <= 1'b0;
      thermal_trim_enable_cmd_out <= 1'b0;
      row_bank_addr_out           <= '0;
      row_index_out               <= '0;
      refresh_row_counter_out     <= PCD_REFRESH_RST;
    end else if (ce_in) begin
      open_row_cmd_out            <= is_open;
      bank_close_cmd_out          <= is_close || is_ref_close;
      refresh_open_cmd_out        <= is_ref_open;
      refresh_close_cmd_out       <= is_ref_close;
      deep_sleep_cmd_out          <= is_deep;
      light_sleep_cmd_out         <= is_nap;
      light_sleep_if_cmd_out      <= is_nap_if;
      row_standby_cmd_out         <= is_idle_power_state;
      attention_cmd_out           <= is_active_listen_state;
      thermal_trim_cmd_out        <= is_trim;
      thermal_trim_enable_cmd_out <= is_trim_en;
      refresh_row_counter_out     <= refresh_q;
      if (row_vld) begin
        row_bank_addr_out <= row_pkt[PCD_ROW_BANK_HI:PCD_ROW_BANK_LO];
        row_index_out     <= is_ref_open ? refresh_q : row_pkt[PCD_ROW_INDEX_HI:0];
      end
    end
  end

  // column strobes, retire with its byte mask, extended close
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      col_write_out           <= 1'b0;
      col_read_out            <= 1'b0;
      col_bank_addr_out       <= '0;
      column_index_out        <= '0;
      retire_out              <= 1'b0;
      retire_bank_addr_out    <= '0;
      retire_column_out       <= '0;
      lane_a_byte_enables_out <= PCD_ALL_BYTES;
      lane_b_byte_enables_out <= PCD_ALL_BYTES;
      ext_bank_close_cmd_out  <= 1'b0;
      ext_bank_addr_out       <= '0;
    end else if (ce_in) begin
      col_write_out          <= is_write;
      col_read_out           <= is_read;
      retire_out             <= is_retire;
      ext_bank_close_cmd_out <= is_ext_close;
      if (col_take) begin
        col_bank_addr_out <= col_pkt[PCD_COL_BANK_HI:PCD_COL_BANK_LO];
        column_index_out  <= col_pkt[PCD_COL_IDX_HI:PCD_COL_IDX_LO];
        ext_bank_addr_out <= col_pkt[PCD_EXT_BANK_HI:PCD_EXT_BANK_LO];
      end
      if (is_retire) begin
        retire_bank_addr_out <= wbuf_bank_q;
        retire_column_out    <= wbuf_col_q;
        if (col_pkt[PCD_COL_KIND]) begin
          lane_a_byte_enables_out <= col_pkt[PCD_LANE_A_HI:PCD_LANE_A_LO];
          lane_b_byte_enables_out <= col_pkt[PCD_LANE_B_HI:0];
        end else begin
          lane_a_byte_enables_out <= PCD_ALL_BYTES;
          lane_b_byte_enables_out <= PCD_ALL_BYTES;
        end
      end
    end
  end

  // power state output registered from the next-state value pwr_d
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      power_state_out <= PCD_PWR_RST;
    end else if (ce_in) begin
      power_state_out <= pwr_d;
    end
  end
endmodule

// ===== shared/pcd_pkg.sv
/*
  Shared constants for the packet command decoder: pin counts, slot counts,
  packet field positions, opcode patterns, reset values and the power states.
  Assumes packets arrive MSB-slot first, as assembled by pcd_deser.
*/
package pcd_pkg;

  // packet geometry
  localparam int PCD_ROW_PINS  = 3;
  localparam int PCD_COL_PINS  = 5;
  localparam int PCD_ROW_SLOTS = 8;
  localparam int PCD_COL_SLOTS = 8;
  localparam int PCD_ROW_BITS  = PCD_ROW_PINS * PCD_ROW_SLOTS;
  localparam int PCD_COL_BITS  = PCD_COL_PINS * PCD_COL_SLOTS;

  // row packet fields
  localparam int PCD_ROW_SEL_T    = 23;
  localparam int PCD_ROW_SEL_F    = 22;
  localparam int PCD_ROW_UNIT_HI  = 21;
  localparam int PCD_ROW_UNIT_LO  = 18;
  localparam int PCD_ROW_BANK_HI  = 17;
  localparam int PCD_ROW_BANK_LO  = 13;
  localparam int PCD_ROW_KIND     = 12;
  localparam int PCD_ROW_INDEX_HI = 8;
  localparam int PCD_ROW_OP_HI    = 10;

  // column slot fields
  localparam int PCD_COL_START    = 39;
  localparam int PCD_COL_UNIT_HI  = 38;
  localparam int PCD_COL_UNIT_LO  = 34;
  localparam int PCD_COL_BANK_HI  = 33;
  localparam int PCD_COL_BANK_LO  = 29;
  localparam int PCD_COL_IDX_HI   = 28;
  localparam int PCD_COL_IDX_LO   = 22;
  localparam int PCD_COL_OP_HI    = 21;
  localparam int PCD_COL_OP_LO    = 18;
  localparam int PCD_COL_KIND     = 16;
  localparam int PCD_LANE_A_HI    = 15;
  localparam int PCD_LANE_A_LO    = 8;
  localparam int PCD_LANE_B_HI    = 7;
  localparam int PCD_EXT_UNIT_HI  = 15;
  localparam int PCD_EXT_UNIT_LO  = 11;
  localparam int PCD_EXT_BANK_HI  = 10;
  localparam int PCD_EXT_BANK_LO  = 6;
  localparam int PCD_EXT_OP_HI    = 5;
  localparam int PCD_EXT_OP_LO    = 1;

  // frame marker masks on the first slot
  localparam logic [PCD_ROW_PINS-1:0] PCD_ROW_FRAME = 3'h6;
  localparam logic [PCD_COL_PINS-1:0] PCD_COL_FRAME = 5'h10;

  // opcode patterns
  localparam logic [4:0] PCD_ROP_CLOSE   = 5'h18;
  localparam logic [6:0] PCD_ROP_REF_OPN = 7'h0C;
  localparam logic [6:0] PCD_ROP_REF_CLS = 7'h54;
  localparam logic [4:0] PCD_ROP_DEEP    = 5'h01;
  localparam logic [4:0] PCD_ROP_NAP     = 5'h02;
  localparam logic [4:0] PCD_ROP_NAP_IF  = 5'h03;
  localparam logic [2:0] PCD_ROP_LOW_PWR = 3'h0;
  localparam logic [2:0] PCD_ROP_TRIM    = 3'h1;
  localparam logic [2:0] PCD_ROP_TRIM_EN = 3'h2;
  localparam logic [2:0] PCD_COP_WRITE   = 3'h1;
  localparam logic [2:0] PCD_COP_READ    = 3'h3;
  localparam logic [2:0] PCD_COP_RETIRE  = 3'h0;
  localparam logic [4:0] PCD_LAST_BANK   = 5'h1F;

  // reset values
  localparam logic [8:0] PCD_REFRESH_RST = 9'h000;
  localparam logic [7:0] PCD_ALL_BYTES   = 8'hFF;

  // power states, one-hot
  typedef enum logic [3:0] {
    PCD_ACTIVE_LISTEN = 4'h1,
    PCD_IDLE_POWER    = 4'h2,
    PCD_LIGHT_SLEEP   = 4'h4,
    PCD_DEEP_POWER    = 4'h8
  } pcd_pwr_t;

  localparam pcd_pwr_t PCD_PWR_RST = PCD_IDLE_POWER;

  // unit address compare, used for column and extended packets
  function automatic logic pcd_unit_eq(input logic [4:0] a, input logic [4:0] b);
    pcd_unit_eq = (a == b);
  endfunction

endpackage

// ===== design/pcd_deser.sv
/*
  Deserialiser for one pin group: collects SLOTS slots into one packet once a
  frame marker shows in the first slot, then pulses valid for one cycle.
  Assumes edge_in marks receive-clock edges and pins_in is already synchronised.
*/
`timescale 1ns/10ps
module pcd_deser #(
  parameter int               PINS  = 3,
  parameter int               SLOTS = 8,
  parameter logic [PINS-1:0]  FRAME = '1
) (
  input  wire logic                  clk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  ce_in,
  input  wire logic                  edge_in,
  input  wire logic [PINS-1:0]       pins_in,
  output logic      [PINS*SLOTS-1:0] packet_out,
  output logic                       valid_out
);
  localparam int CW = $clog2(SLOTS + 1);

  logic [CW-1:0] cnt_q;

  // slot counter and shift register; a new frame only starts when idle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q      <= '0;
      packet_out <= '0;
      valid_out  <= 1'b0;
    end else if (ce_in) begin
      valid_out <= 1'b0;
      if (edge_in && (cnt_q != '0 || (pins_in & FRAME) != '0)) begin
        packet_out <= {packet_out[PINS*SLOTS-PINS-1:0], pins_in};
        if (cnt_q == CW'(SLOTS - 1)) begin
          cnt_q     <= '0;
          valid_out <= 1'b1;
        end else begin
          cnt_q <= cnt_q + CW'(1);
        end
      end
    end
  end
endmodule

// ===== design/pcd_unit_match.sv
/*
  Row unit match: combines the two high select bits with the four low address
  bits and compares against the configured unit identifier.
  Assumes the inputs are stable fields of a complete row packet.
*/
`timescale 1ns/10ps
module pcd_unit_match (
  input  wire logic       sel_true_in,
  input  wire logic       sel_false_in,
  input  wire logic [3:0] unit_low_in,
  input  wire logic [4:0] unit_identifier_in,
  output logic            unit_hit_out,
  output logic            broadcast_out
);
  // broadcast, single select or nothing
  always_comb begin
    broadcast_out = sel_true_in & sel_false_in;
    unit_hit_out  = 1'b0;
    if (broadcast_out) begin
      unit_hit_out = 1'b1;
    end else if (sel_true_in) begin
      unit_hit_out = (unit_identifier_in == {1'b1, unit_low_in});
    end else if (sel_false_in) begin
      unit_hit_out = (unit_identifier_in == {1'b0, unit_low_in});
    end
  end
endmodule

// ===== verif/pcd_ctrl_model.sv
/* controller model: frames row and column packets onto the pin groups.
   Assumes the decoder samples pins on both receive-clock edges. */
`timescale 1ns/10ps
module pcd_ctrl_model (
  output logic       rclk_out,
  output logic [2:0] row_out,
  output logic [4:0] col_out
);
  // link idle: clock still, no frame marker on either group
  initial begin
    rclk_out = 1'b0;
    row_out = 3'h0;
    col_out = 5'h00;
  end
  // eight slots, first slot MSBs; pins change midway between edges
  task automatic send(input logic [23:0] r, input logic [39:0] c);
    for (int i = 7; i >= 0; i--) begin
      row_out = r[i*3+:3];
      col_out = c[i*5+:5];
      #50 rclk_out = !rclk_out;
      #50;
    end
    row_out = 3'h0;
    col_out = 5'h00;
  endtask
endmodule

// ===== verif/pcd_decoder_props.sv
/* concurrent checks on the decoder's top ports.
   Assumes clk_in with asynchronous active-low resetn_in. */
`timescale 1ns/10ps
module pcd_decoder_props (
  input wire logic       clk_in,
  input wire logic       resetn_in,
  input wire logic       open_row_cmd_out,
  input wire logic       bank_close_cmd_out,
  input wire logic       refresh_open_cmd_out,
  input wire logic       refresh_close_cmd_out,
  input wire logic       deep_sleep_cmd_out,
  input wire logic       col_write_out,
  input wire logic       col_read_out,
  input wire logic       retire_out,
  input wire logic [4:0] row_bank_addr_out,
  input wire logic [8:0] row_index_out,
  input wire logic [8:0] refresh_row_counter_out,
  input wire logic [3:0] power_state_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // strobes, power moves, column acceptance and the refresh counter step
  a_strobe_pulse: assert property ((open_row_cmd_out | col_write_out | retire_out)
    |=> !(open_row_cmd_out | col_write_out | retire_out)) else $error("strobe too wide");
  a_refclose_close: assert property (refresh_close_cmd_out |-> bank_close_cmd_out)
    else $error("refresh close without bank close");
  a_open_wakes: assert property (open_row_cmd_out |-> ##[0:1] power_state_out == 4'h1)
    else $error("row open did not wake");
  a_deep_enter: assert property (deep_sleep_cmd_out |-> ##[0:1] power_state_out == 4'h8)
    else $error("deep sleep not entered");
  a_col_active_listen_state: assert property ((col_write_out | col_read_out)
    |-> $past(power_state_out) == 4'h1) else $error("column taken outside attention");
  a_read_keeps: assert property (col_read_out |-> !retire_out)
    else $error("read retired the buffer");
  a_rw_excl: assert property (!(col_write_out && col_read_out))
    else $error("read and write together");
  a_refresh_step: assert property (refresh_open_cmd_out |-> ##2
    refresh_row_counter_out == row_index_out + 9'(row_bank_addr_out == 5'h1F))
    else $error("refresh counter step wrong");
endmodule
bind pcd_decoder pcd_decoder_props i_props (.clk_in(clk_in), .resetn_in(resetn_in),
  .open_row_cmd_out(open_row_cmd_out), .bank_close_cmd_out(bank_close_cmd_out),
  .refresh_open_cmd_out(refresh_open_cmd_out), .refresh_close_cmd_out(refresh_close_cmd_out),
  .deep_sleep_cmd_out(deep_sleep_cmd_out), .col_write_out(col_write_out),
  .col_read_out(col_read_out), .retire_out(retire_out), .row_bank_addr_out(row_bank_addr_out),
  .row_index_out(row_index_out), .refresh_row_counter_out(refresh_row_counter_out),
  .power_state_out(power_state_out));

// ===== verif/tb_top.sv
/* bench top: random row and column packets, strobes and state against a model.
   Assumes the decoder's link timing of a few clocks after each frame. */
`timescale 1ns/10ps
module tb_top;
  import pcd_pkg::*;
  logic clk_in = 0, resetn_in = 0, ce_in = 1;
  wire logic rclk_in;
  wire logic [2:0] row_pins_in;
  wire logic [4:0] col_pins_in;
  logic [4:0] unit_identifier_in = 0, row_bank_addr_out, col_bank_addr_out;
  logic [4:0] retire_bank_addr_out, ext_bank_addr_out;
  logic open_row_cmd_out, bank_close_cmd_out, refresh_open_cmd_out, refresh_close_cmd_out;
  logic deep_sleep_cmd_out, light_sleep_cmd_out, light_sleep_if_cmd_out, row_standby_cmd_out;
  logic attention_cmd_out, thermal_trim_cmd_out, thermal_trim_enable_cmd_out;
  logic col_write_out, col_read_out, retire_out, ext_bank_close_cmd_out;
  logic [8:0] row_index_out, refresh_row_counter_out;
  logic [6:0] column_index_out, retire_column_out, tagc;
  logic [7:0] lane_a_byte_enables_out, lane_b_byte_enables_out;
  logic [3:0] power_state_out, cacc;
  logic [10:0] acc;
  int failures = 0, checks_done = 0, st = 2, bufv = 0;
  logic [10:0] ops [11] = '{11'h600, 11'h0C0, 11'h540, 11'h010, 11'h020, 11'h030, 11'h008,
                            11'h001, 11'h002, 11'h638, 11'h000};
  pcd_decoder i_dut (.*);
  pcd_ctrl_model i_ctrl (.rclk_out(rclk_in), .row_out(row_pins_in), .col_out(col_pins_in));
  always #12.5 clk_in = !clk_in;
  // gather every strobe seen since the last packet
  always @(posedge clk_in) begin
    acc <= acc | {open_row_cmd_out, bank_close_cmd_out, refresh_open_cmd_out,
                  refresh_close_cmd_out, deep_sleep_cmd_out, light_sleep_cmd_out,
                  light_sleep_if_cmd_out, row_standby_cmd_out, attention_cmd_out,
                  thermal_trim_cmd_out, thermal_trim_enable_cmd_out};
    cacc <= cacc | {col_write_out, col_read_out, retire_out, ext_bank_close_cmd_out};
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (exp !== got) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one row packet; expected strobes and power move from the opcode
  task automatic row_pkt(logic t, logic f, logic [3:0] lo, logic av, logic [10:0] op);
    logic hit, bc, z;
    logic [10:0] e;
    #1;
    bc = t & f;
    hit = bc | ((t ^ f) && unit_identifier_in == {t, lo});
    z = op[2:0] == 3'h0;
    e = {hit && av, 10'h000};
    if (hit && !av)
      e = {1'b0, (op[10:6] == 5'h18 || op[10:4] == 7'h54) && z, op[10:4] == 7'h0C && z,
           op[10:4] == 7'h54 && z, op[8:4] == 5'h01 && z, op[8:4] == 5'h02 && z,
           op[8:4] == 5'h03 && z, op[3] && z, !op[3] && z && op != 0,
           op[10:4] == 0 && op[2:0] == 3'h1, op[10:4] == 0 && op[2:0] == 3'h2};
    // deep sleep from any state, light sleep only from attention or standby; standby only from attention
    if (e[6])
      st = 8;
    else if ((e[5] && st <= 2) || (e[4] && st == 2))
      st = 4;
    else if (e[3] && st == 1)
      st = 2;
    else if (st != 1 && (e[10] || (e[2] && !bc)))
      st = 1;
    {acc, cacc} = '0;
    i_ctrl.send({t, f, lo, 5'($urandom), av, 1'b0, op}, 40'h0);
    repeat (8) @(posedge clk_in);
    check("row strobes", e, acc);
    check("power state", st, power_state_out);
    if (hit && av)
      check("row index", op[8:0], row_index_out);
  endtask
  // one column packet with mask or extended remainder
  task automatic col_pkt(logic [4:0] u, logic [3:0] op, logic k, logic [4:0] eu, logic [4:0] x);
    logic ok, hit, wr, rd, rt, xc;
    logic [6:0] c;
    logic [15:0] m;
    #1;
    c = 7'($urandom);
    m = k ? 16'($urandom) : {eu, 1'b0, 4'($urandom), x, 1'b0};
    ok = st == 1;
    hit = ok && u == unit_identifier_in;
    wr = hit && op[2:0] == 3'h1;
    rd = hit && op[2:0] == 3'h3;
    rt = ok && bufv != 0 && (!hit || op[2:0] <= 3'h1);
    xc = ok && !k && eu == unit_identifier_in && x[4] && !x[0];
    if ((hit && op[3]) || (ok && !k && eu == unit_identifier_in && x[1:0] == 2'b10))
      st = 2;
    {acc, cacc} = '0;
    i_ctrl.send(24'h0, {1'b1, u, 1'b0, 4'($urandom), c, op, 1'b0, k, m});
    repeat (8) @(posedge clk_in);
    check("column strobes", {wr, rd, rt, xc}, cacc);
    check("power state", st, power_state_out);
    if (hit)
      check("column index", c, column_index_out);
    if (rt) begin
      check("byte enables", k ? m : 16'hFFFF, {lane_a_byte_enables_out, lane_b_byte_enables_out});
      check("retire column", tagc, retire_column_out);
    end
    bufv = wr ? 1 : (rt ? 0 : bufv);
    tagc = wr ? c : tagc;
  endtask
  // main sequence: reset values, then mixed random traffic
  initial begin
    void'($urandom(2));
    repeat (2) @(posedge clk_in);
    #1 resetn_in = 1;
    unit_identifier_in = 5'($urandom);
    repeat (4) @(posedge clk_in);
    check("reset state", 4'h2, power_state_out);
    check("reset enables", 16'hFFFF, {lane_a_byte_enables_out, lane_b_byte_enables_out});
    $display("test reset done");
    for (int i = 0; i < 150; i++) begin
      automatic logic t = 1'($urandom);
      if ($urandom % 2)
        row_pkt(t, t ? 1'($urandom) : 1'b1, ($urandom % 2) ? unit_identifier_in[3:0] :
                4'($urandom), ($urandom % 3) == 0, ops[$urandom % 11]);
      else
        col_pkt(($urandom % 2) ? unit_identifier_in : 5'($urandom),
                {($urandom % 4) == 0, 3'($urandom)}, 1'($urandom),
                ($urandom % 2) ? unit_identifier_in : 5'($urandom), 5'($urandom));
    end
    $display("test random traffic done");
    finish_test();
  end
  // watchdog well beyond the expected run length
  initial begin
    #400000;
    failures++;
    finish_test();
  end
endmodule
